// ---- test/code_table_model.sv ----
// Behavioural 8/16 code table answering both candidate streams of the encoder
`timescale 1ns/1ns
`default_nettype none
module code_table_model (
    // Request from the encoder
    input wire sector_sync_pkg::lk_req_t lk_req,
    // Answers for stream 1 and stream 2
    output var sector_sync_pkg::lk_ans_t lk_ans1,
    output var sector_sync_pkg::lk_ans_t lk_ans2
);
    import sector_sync_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Words are picked so that the bench can decode them, not for run length
    function automatic lk_ans_t answer(input logic [7:0] b, input logic [1:0] st);
        lk_ans_t a;
        a.main_nxt = MS1;
        // For top-bit bytes the other column leads to State 3, so the two streams then differ in state
        a.alt_nxt = b[7] ? 2'h2 : MS1;
        if (b < SUB_LIMIT) begin
            // Flat word and its inverted twin pull the DSV in opposite directions
            a.main_cw = 16'h0000;
            a.alt_cw = 16'h8000;
            a.alt_ok = 1'b1;
        end else begin
            a.main_cw = {b, 8'h11};
            a.alt_cw = {b, 8'h21};
            // Only top-bit bytes pass the run-length test in the other column, and only from State 1 or 4
            a.alt_ok = b[7] && (st == MS1 || st == MS4);
        end
        return a;
    endfunction : answer

    always_comb begin
        lk_ans1 = answer(lk_req.data_byte, lk_req.st1);
        lk_ans2 = answer(lk_req.data_byte, lk_req.st2);
    end
endmodule : code_table_model
`default_nettype wire

// ---- test/sector_sync_encoder_tb_top.sv ----
// Testbench of the sector sync encoder: sector layout, SYNC order and DSV control
`timescale 1ns/1ns
`default_nettype none
module sector_sync_encoder_tb_top;
    import sector_sync_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic mod_start = 1'b0;
    logic [7:0] in_byte = 8'h00;
    logic in_valid = 1'b0;
    logic in_ready;
    lk_req_t lk_req;
    lk_ans_t lk_ans1;
    lk_ans_t lk_ans2;
    logic ch_bit;
    logic ch_valid;
    logic frame_start;
    int n_errors = 0;
    int n_tests = 0;
    int n_cycles = 0;
    int idx = 0;
    int dsv = 0;
    // Stimulus mode: 0 layout bytes, 1 substitution bytes, 2 column-choice bytes
    logic [1:0] mode = 2'h0;
    logic tab_b = 1'b0;
    logic lvl = 1'b0;

    sector_sync_encoder u_sector_sync_encoder (
        .sys_clk(sys_clk), .resetn(resetn), .mod_start(mod_start),
        .in_byte(in_byte), .in_valid(in_valid), .in_ready(in_ready),
        .lk_req(lk_req), .lk_ans1(lk_ans1), .lk_ans2(lk_ans2),
        .ch_bit(ch_bit), .ch_valid(ch_valid), .frame_start(frame_start)
    );
    code_table_model u_code_table_model (.lk_req(lk_req), .lk_ans1(lk_ans1), .lk_ans2(lk_ans2));

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic give_verdict();
        $display("comparisons=%0d mismatches=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Byte value tells its frame (row and half), so misplaced rows show up
    function automatic logic [7:0] byte_at(input int i);
        return (mode == 2'h1) ? 8'h10 : (mode == 2'h2) ? 8'h80 : 8'h60 + 8'((i / 91) % 26);
    endfunction : byte_at

    function automatic int sync_idx(input int f);
        int row;
        row = (f / 2) % 13;
        if (f % 2 == 0)
            return (row == 0) ? 0 : (row - 1) % 4 + 1;
        return (row < 5) ? 5 : (row < 9) ? 6 : 7;
    endfunction : sync_idx

    always @(posedge sys_clk) begin
        n_cycles++;
        if (n_cycles == 70000) begin
            n_errors++;
            give_verdict();
        end
    end

    // Upstream source: whole rows of 182 bytes in row order
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn)
            idx = 0;
        else if (in_valid && in_ready)
            idx = idx + 1;
    end

    always @(negedge sys_clk) begin
        in_valid <= resetn;
        in_byte <= byte_at(idx);
    end

    task automatic do_reset(input logic [1:0] m);
        @(negedge sys_clk);
        resetn = 1'b0;
        mode = m;
        tab_b = 1'b0;
        lvl = 1'b0;
        dsv = 0;
        repeat (20) @(negedge sys_clk);
        resetn = 1'b1;
        @(negedge sys_clk);
        check(32'({in_ready, ch_valid, frame_start, ch_bit}), 32'h0);
        mod_start = 1'b1;
        @(negedge sys_clk);
        mod_start = 1'b0;
    endtask : do_reset

    // Decodes one sync frame from the channel bits and judges SYNC and code words
    task automatic collect_frame(input int f, input logic allow_alt);
        logic [31:0] w;
        logic [7:0] b;
        logic [15:0] main_w;
        logic [15:0] alt_w;
        logic [31:0] pri;
        logic [31:0] sec;
        int n;
        w = 32'h0;
        b = byte_at(f * 91);
        // Words of the table model: flat pair below the limit, byte plus marker above it
        main_w = (b < SUB_LIMIT) ? 16'h0000 : {b, 8'h11};
        alt_w = (b < SUB_LIMIT) ? 16'h8000 : {b, 8'h21};
        pri = {tab_b ? SYNC_B_PRI[sync_idx(f)] : SYNC_A_PRI[sync_idx(f)], SYNC_TAIL};
        sec = {tab_b ? SYNC_B_SEC[sync_idx(f)] : SYNC_A_SEC[sync_idx(f)], SYNC_TAIL};
        n = 0;
        @(negedge sys_clk);
        while (frame_start !== 1'b1 && n < 2000) begin
            n++;
            @(negedge sys_clk);
        end
        for (int i = 0; i < 1488; i++) begin
            check(32'(ch_valid), 32'h1);
            check(32'(frame_start), 32'(i == 0));
            w = {w[30:0], ch_bit ^ lvl};
            lvl = ch_bit;
            dsv += ch_bit ? 1 : -1;
            if (i == 31)
                check(w, (w === sec) ? sec : pri);
            else if (i > 31 && i % 16 == 15)
                check(32'(w[15:0]), 32'((allow_alt && w[15:0] === alt_w) ? alt_w : main_w));
            @(negedge sys_clk);
        end
        check(32'(ch_valid), 32'h0);
        // A column-swapped last word leaves State 3, so the next SYNC comes from the second table
        tab_b = (w[15:0] === {b, 8'h21});
    endtask : collect_frame

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic test_dsv_choice();
        // All-main coding would drift by 1456 per frame; choices must hold it near zero
        for (int f = 0; f < 4; f++) begin
            collect_frame(f, 1'b1);
            check(32'(dsv <= 100 && dsv >= -100), 32'h1);
        end
        $display("test_dsv_choice done");
    endtask : test_dsv_choice

    task automatic test_sector_layout();
        // Two extra frames show the wrap from row 12 back to row 0
        for (int f = 0; f < 28; f++) begin
            collect_frame(f, 1'b0);
            // Some frames drift by hundreds (546 for byte 8'h60); only the pick between the two SYNC codes keeps the total in range
            check(32'(dsv <= 1023 && dsv >= -1024), 32'h1);
        end
        $display("test_sector_layout done");
    endtask : test_sector_layout

    task automatic test_column_choice();
        // Column choice in both streams, then in one stream only, and SYNC from either table
        for (int f = 0; f < 4; f++) begin
            collect_frame(f, 1'b1);
            check(32'(dsv <= 1023 && dsv >= -1024), 32'h1);
        end
        $display("test_column_choice done");
    endtask : test_column_choice

    initial begin
        do_reset(2'h1);
        test_dsv_choice();
        // Second reset lands in mid-frame on purpose
        do_reset(2'h0);
        test_sector_layout();
        do_reset(2'h2);
        test_column_choice();
        give_verdict();
    end
endmodule : sector_sync_encoder_tb_top
`default_nettype wire

// ---- verilog/sector_sync_encoder.sv ----
// Physical sector builder: SYNC insertion, 8/16 stream pair selection, DSV control, NRZI output
`timescale 1ns/1ns
`default_nettype none
module sector_sync_encoder (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Control
    input wire logic mod_start,
    // Recording frame bytes
    input wire logic [7:0] in_byte,
    input wire logic in_valid,
    output logic in_ready,
    // Code table lookup
    output sector_sync_pkg::lk_req_t lk_req,
    input wire sector_sync_pkg::lk_ans_t lk_ans1,
    input wire sector_sync_pkg::lk_ans_t lk_ans2,
    // Channel bits
    output logic ch_bit,
    output logic ch_valid,
    output logic frame_start
);
    import sector_sync_pkg::*;

    fsm_t fsm_r;
    strm_t s1_r, s2_r;
    logic signed [DSV_W-1:0] start_dsv_r;
    logic start_lvl_r;
    logic [1:0] state_r;
    logic [3:0] row_r;
    logic half_r;
    logic [6:0] pos_r;
    logic [3:0] bitc_r;
    logic [WORDS-1:0] hist_out_r;
    logic [15:0] mem0 [0:WORDS-1];
    logic [15:0] mem1 [0:WORDS-1];

    ////////////////////////////////////////////////////////////////////////////
    // SYNC code selection
    logic [3:0] row_m1;
    logic [2:0] sync_idx;
    logic [15:0] pri_hi, sec_hi;
    nrzi_t np, ns;

    always_comb begin
        row_m1 = row_r - 4'h1;
        if (!half_r)
            sync_idx = (row_r == 4'h0) ? 3'h0 : {1'b0, row_m1[1:0]} + 3'h1;
        else if (row_r <= 4'h4)
            sync_idx = 3'h5;
        else if (row_r <= 4'h8)
            sync_idx = 3'h6;
        else
            sync_idx = 3'h7;
        pri_hi = state_r[1] ? SYNC_B_PRI[sync_idx] : SYNC_A_PRI[sync_idx];
        sec_hi = state_r[1] ? SYNC_B_SEC[sync_idx] : SYNC_A_SEC[sync_idx];
        np = nrzi_run({pri_hi, SYNC_TAIL}, SYNC_BITS, start_lvl_r);
        ns = nrzi_run({sec_hi, SYNC_TAIL}, SYNC_BITS, start_lvl_r);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Byte choice between the two streams
    logic [DSV_W-1:0] m1, m2;
    logic ok1, ok2;
    strm_t b1, b2, n1, n2;
    logic [15:0] cw1, cw2;
    logic [1:0] ns1, ns2;
    nrzi_t r1, r2;

    always_comb begin
        m1 = mag(s1_r.dsv);
        m2 = mag(s2_r.dsv);
        // Substitution always exists below the limit; the column swap only from state 1 or 4
        ok1 = (lk_req.data_byte < SUB_LIMIT) | ((s1_r.st == MS1 || s1_r.st == MS4) & lk_ans1.alt_ok);
        ok2 = (lk_req.data_byte < SUB_LIMIT) | ((s2_r.st == MS1 || s2_r.st == MS4) & lk_ans2.alt_ok);
        b1 = s1_r;
        b2 = s2_r;
        cw1 = lk_ans1.main_cw;
        ns1 = lk_ans1.main_nxt;
        cw2 = lk_ans2.main_cw;
        ns2 = lk_ans2.main_nxt;
        if (ok1 && ok2) begin
            // Ties go to stream 1
            b1 = (m1 <= m2) ? s1_r : s2_r;
            b2 = b1;
            cw1 = (m1 <= m2) ? lk_ans1.main_cw : lk_ans2.main_cw;
            ns1 = (m1 <= m2) ? lk_ans1.main_nxt : lk_ans2.main_nxt;
            cw2 = (m1 <= m2) ? lk_ans1.alt_cw : lk_ans2.alt_cw;
            ns2 = (m1 <= m2) ? lk_ans1.alt_nxt : lk_ans2.alt_nxt;
        end else if (ok1 && m1 <= m2) begin
            b2 = s1_r;
            cw2 = lk_ans1.alt_cw;
            ns2 = lk_ans1.alt_nxt;
        end else if (ok2 && m2 <= m1) begin
            b1 = s2_r;
            cw1 = lk_ans2.main_cw;
            ns1 = lk_ans2.main_nxt;
            cw2 = lk_ans2.alt_cw;
            ns2 = lk_ans2.alt_nxt;
        end
        // Otherwise the lone choice is ignored and both keep their prescribed word
        r1 = nrzi_run({16'h0000, cw1}, CW_BITS, b1.lvl);
        r2 = nrzi_run({16'h0000, cw2}, CW_BITS, b2.lvl);
        n1 = b1;
        n1.dsv = b1.dsv + r1.dsv;
        n1.lvl = r1.lvl;
        n1.st = ns1;
        n1.hist[pos_r] = 1'b0;
        n2 = b2;
        n2.dsv = b2.dsv + r2.dsv;
        n2.lvl = r2.lvl;
        n2.st = ns2;
        n2.hist[pos_r] = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // End of frame: stream pick and SYNC swap trial
    strm_t sel;
    logic [15:0] cur_hi, alt_hi;
    nrzi_t cs, as;
    logic par, oor, swap;
    logic signed [DSV_W-1:0] data_dsv, alt_dsv;

    always_comb begin
        sel = (mag(s1_r.dsv) <= mag(s2_r.dsv)) ? s1_r : s2_r;
        cur_hi = sel.hist[0] ? sec_hi : pri_hi;
        alt_hi = sel.hist[0] ? pri_hi : sec_hi;
        cs = sel.hist[0] ? ns : np;
        as = sel.hist[0] ? np : ns;
        // A SYNC with other one-parity inverts every later level, so the data part flips sign
        par = cs.lvl ^ as.lvl;
        data_dsv = sel.dsv - sel.dsv_sync;
        alt_dsv = start_dsv_r + as.dsv + (par ? -data_dsv : data_dsv);
        oor = (sel.dsv > DSV_MAX) || (sel.dsv < DSV_MIN);
        swap = oor && (mag(alt_dsv) < mag(sel.dsv));
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer and stream registers
    logic last_bit;
    logic [15:0] word_now;
    assign last_bit = (bitc_r == 4'h0);
    assign word_now = hist_out_r[pos_r] ? mem1[pos_r] : mem0[pos_r];

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            fsm_r <= ST_IDLE;
            in_ready <= 1'b0;
            lk_req <= '0;
            pos_r <= 7'h00;
            bitc_r <= LAST_BIT;
        end else begin
            case (fsm_r)
                ST_IDLE: begin
                    if (mod_start)
                        fsm_r <= ST_SYNC;
                end
                ST_SYNC: begin
                    fsm_r <= ST_TAKE;
                    pos_r <= FIRST_DATA_POS;
                    in_ready <= 1'b1;
                end
                ST_TAKE: begin
                    if (in_valid && in_ready) begin
                        lk_req <= '{data_byte: in_byte, st1: s1_r.st, st2: s2_r.st};
                        in_ready <= 1'b0;
                        fsm_r <= ST_CODE;
                    end
                end
                ST_CODE: begin
                    pos_r <= pos_r + 7'h01;
                    if (pos_r == LAST_POS) begin
                        fsm_r <= ST_DECIDE;
                    end else begin
                        fsm_r <= ST_TAKE;
                        in_ready <= 1'b1;
                    end
                end
                ST_DECIDE: begin
                    fsm_r <= ST_SEND;
                    pos_r <= 7'h00;
                    bitc_r <= LAST_BIT;
                end
                ST_SEND: begin
                    bitc_r <= bitc_r - 4'h1;
                    if (last_bit) begin
                        pos_r <= pos_r + 7'h01;
                        if (pos_r == LAST_POS)
                            fsm_r <= ST_SYNC;
                    end
                end
                default: fsm_r <= ST_IDLE;
            endcase
        end
    end

    // Row and half order of the sector
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            row_r <= 4'h0;
            half_r <= 1'b0;
        end else if (fsm_r == ST_IDLE && mod_start) begin
            row_r <= 4'h0;
            half_r <= 1'b0;
        end else if (fsm_r == ST_SEND && last_bit && pos_r == LAST_POS) begin
            half_r <= ~half_r;
            if (half_r)
                row_r <= (row_r == LAST_ROW) ? 4'h0 : row_r + 4'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s1_r <= '0;
            s2_r <= '0;
        end else if (fsm_r == ST_SYNC) begin
            s1_r <= '{dsv: start_dsv_r + np.dsv, dsv_sync: start_dsv_r + np.dsv, lvl: np.lvl,
                      st: MS1, hist: '0};
            s2_r <= '{dsv: start_dsv_r + ns.dsv, dsv_sync: start_dsv_r + ns.dsv, lvl: ns.lvl,
                      st: MS1, hist: '1};
        end else if (fsm_r == ST_CODE) begin
            s1_r <= n1;
            s2_r <= n2;
        end
    end

    // Column 0 holds what stream 1 took at each position, column 1 stream 2
    always_ff @(posedge sys_clk) begin
        if (fsm_r == ST_SYNC) begin
            mem0[0] <= pri_hi;
            mem0[1] <= SYNC_TAIL;
            mem1[0] <= sec_hi;
            mem1[1] <= SYNC_TAIL;
        end else if (fsm_r == ST_CODE) begin
            mem0[pos_r] <= cw1;
            mem1[pos_r] <= cw2;
        end
    end

    // Committed DSV, level and state carried into the next frame
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            start_dsv_r <= DSV_ZERO;
            start_lvl_r <= 1'b0;
            state_r <= MS1;
            hist_out_r <= '0;
        end else if (fsm_r == ST_IDLE && mod_start) begin
            start_dsv_r <= DSV_ZERO;
        end else if (fsm_r == ST_DECIDE) begin
            start_dsv_r <= swap ? alt_dsv : sel.dsv;
            start_lvl_r <= sel.lvl ^ (swap & par);
            state_r <= sel.st;
            hist_out_r <= {sel.hist[WORDS-1:1], sel.hist[0] ^ swap};
        end
    end

    // NRZI serialiser, msb first
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ch_bit <= 1'b0;
            ch_valid <= 1'b0;
            frame_start <= 1'b0;
        end else begin
            ch_valid <= (fsm_r == ST_SEND);
            frame_start <= (fsm_r == ST_SEND) && (pos_r == 7'h00) && (bitc_r == LAST_BIT);
            if (fsm_r == ST_SEND)
                ch_bit <= ch_bit ^ word_now[bitc_r];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    logic [10:0] bit_cnt_r;
    logic seen_r;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            bit_cnt_r <= 11'h000;
            seen_r <= 1'b0;
        end else if (frame_start) begin
            bit_cnt_r <= 11'h001;
            seen_r <= 1'b1;
        end else if (ch_valid) begin
            bit_cnt_r <= bit_cnt_r + 11'h001;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_take;
        fsm_r == ST_TAKE && in_valid && in_ready;
    endsequence
    sequence s_code_done;
        fsm_r == ST_CODE ##1 (fsm_r == ST_TAKE || fsm_r == ST_DECIDE);
    endsequence

    property p_take;
        s_take |=> s_code_done;
    endproperty
    a_take: assert property (p_take) else $error("byte not coded after take");

    property p_clear;
        fsm_r == ST_IDLE && mod_start |=> start_dsv_r == DSV_ZERO;
    endproperty
    a_clear: assert property (p_clear) else $error("DSV not cleared at start");

    property p_frame_len;
        frame_start && $past(seen_r) |-> $past(bit_cnt_r) == FRAME_BITS;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("sync frame length wrong");

    property p_sync_second;
        fsm_r == ST_SYNC && half_r |-> sync_idx == ((row_r <= 4'h4) ? 3'h5 : (row_r <= 4'h8) ? 3'h6 : 3'h7);
    endproperty
    a_sync_second: assert property (p_sync_second) else $error("second sync code wrong");

    property p_row_step;
        $changed(row_r) && fsm_r != ST_IDLE |-> $past(half_r) &&
            (row_r == $past(row_r) + 4'h1 || (row_r == 4'h0 && $past(row_r) == LAST_ROW));
    endproperty
    a_row_step: assert property (p_row_step) else $error("row order broken");

    property p_both;
        fsm_r == ST_CODE && ok1 && ok2 && m1 <= m2 |=>
            s1_r.st == $past(lk_ans1.main_nxt) && s2_r.st == $past(lk_ans1.alt_nxt) && s1_r.hist[0] == s2_r.hist[0];
    endproperty
    a_both: assert property (p_both) else $error("double choice not forked from stream 1");

    property p_one_win;
        fsm_r == ST_CODE && ok1 && !ok2 && m1 < m2 |=> s2_r.st == $past(lk_ans1.alt_nxt);
    endproperty
    a_one_win: assert property (p_one_win) else $error("lone choice not copied");

    property p_one_lose;
        fsm_r == ST_CODE && ok1 && !ok2 && m1 > m2 |=>
            s1_r.st == $past(lk_ans1.main_nxt) && s2_r.st == $past(lk_ans2.main_nxt);
    endproperty
    a_one_lose: assert property (p_one_lose) else $error("lone choice not ignored");

    property p_pick;
        fsm_r == ST_DECIDE && !oor |=> start_dsv_r == $past(sel.dsv) && mag($past(sel.dsv)) <= mag($past(s2_r.dsv));
    endproperty
    a_pick: assert property (p_pick) else $error("frame stream pick wrong");

    property p_swap;
        fsm_r == ST_DECIDE && swap |=> mag(start_dsv_r) < mag($past(sel.dsv)) && hist_out_r[0] != $past(sel.hist[0]);
    endproperty
    a_swap: assert property (p_swap) else $error("sync swap not applied");

endmodule : sector_sync_encoder
`default_nettype wire

// ---- verilog/sector_sync_pkg.sv ----
// Shared constants, types and helpers of the physical sector sync and DSV encoder
`default_nettype none
package sector_sync_pkg;
    // Sector geometry
    localparam logic [3:0] LAST_ROW = 4'hC;
    localparam logic [6:0] FIRST_DATA_POS = 7'h02;
    localparam logic [6:0] LAST_POS = 7'h5C;
    localparam int WORDS = 93;
    localparam int CW_BITS = 16;
    localparam int SYNC_BITS = 32;
    localparam logic [10:0] FRAME_BITS = 11'h5D0;
    localparam logic [3:0] LAST_BIT = 4'hF;
    // DSV arithmetic
    localparam int DSV_W = 12;
    localparam logic signed [DSV_W-1:0] DSV_ZERO = 12'sh000;
    localparam logic signed [DSV_W-1:0] DSV_ONE = 12'sh001;
    localparam logic signed [DSV_W-1:0] DSV_MAX = 12'sh03F;
    localparam logic signed [DSV_W-1:0] DSV_MIN = 12'shFC0;
    // Byte ranges and modulation states (0..3 stand for State 1..4)
    localparam logic [7:0] SUB_LIMIT = 8'h58;
    localparam logic [1:0] MS1 = 2'h0;
    localparam logic [1:0] MS4 = 2'h3;
    // SYNC codes: leading half per code index, common trailing half
    localparam logic [15:0] SYNC_TAIL = 16'h0011;
    localparam logic [0:7][15:0] SYNC_A_PRI = {16'h1244, 16'h0404, 16'h1004, 16'h0804,
                                               16'h2004, 16'h2244, 16'h2484, 16'h2444};
    localparam logic [0:7][15:0] SYNC_A_SEC = {16'h1204, 16'h0444, 16'h1044, 16'h0844,
                                               16'h2044, 16'h2204, 16'h2084, 16'h2404};
    localparam logic [0:7][15:0] SYNC_B_PRI = {16'h9204, 16'h8444, 16'h9044, 16'h8244,
                                               16'h8844, 16'h8904, 16'h9084, 16'h8884};
    localparam logic [0:7][15:0] SYNC_B_SEC = {16'h9244, 16'h8404, 16'h9004, 16'h8204,
                                               16'h8804, 16'h8104, 16'h8044, 16'h8084};

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SYNC = 3'b001,
        ST_TAKE = 3'b010,
        ST_CODE = 3'b011,
        ST_DECIDE = 3'b100,
        ST_SEND = 3'b101
    } fsm_t;

    // One candidate stream
    typedef struct packed {
        logic signed [DSV_W-1:0] dsv;
        logic signed [DSV_W-1:0] dsv_sync;
        logic lvl;
        logic [1:0] st;
        logic [WORDS-1:0] hist;
    } strm_t;

    // Request to the external code table and its answer for one stream
    typedef struct packed {
        logic [7:0] data_byte;
        logic [1:0] st1;
        logic [1:0] st2;
    } lk_req_t;

    typedef struct packed {
        logic [15:0] main_cw;
        logic [1:0] main_nxt;
        logic alt_ok;
        logic [15:0] alt_cw;
        logic [1:0] alt_nxt;
    } lk_ans_t;

    typedef struct packed {
        logic lvl;
        logic signed [DSV_W-1:0] dsv;
    } nrzi_t;

    // NRZI-convert the low n bits, msb first, and sum the channel levels
    function automatic nrzi_t nrzi_run(input logic [31:0] bits, input int n, input logic lvl);
        nrzi_t r;
        r.lvl = lvl;
        r.dsv = DSV_ZERO;
        for (int i = 31; i >= 0; i--) begin
            if (i < n) begin
                if (bits[i])
                    r.lvl = ~r.lvl;
                r.dsv = r.lvl ? r.dsv + DSV_ONE : r.dsv - DSV_ONE;
            end
        end
        return r;
    endfunction : nrzi_run

    function automatic logic [DSV_W-1:0] mag(input logic signed [DSV_W-1:0] v);
        return v[DSV_W-1] ? -v : v;
    endfunction : mag
endpackage : sector_sync_pkg
`default_nettype wire
